// ==== pkg/shacs_defs.vh ====
`ifndef SHACS_DEFS_VH
`define SHACS_DEFS_VH
// Register byte addresses
`define SHACS_ADDR_CTRL     4'h0
`define SHACS_ADDR_STATUS   4'h4
`define SHACS_ADDR_CHSEL    4'h8
`define SHACS_ADDR_RESULT   4'hc
// Control fields
`define SHACS_CTRL_SERIAL   0
`define SHACS_CTRL_ADC_LSB  8
// Status fields
`define SHACS_ST_BUSY_N     0
`define SHACS_ST_TEST       1
`define SHACS_ST_IN_ROUTE   2
`define SHACS_ST_READBACK   3
`define SHACS_ST_RST_SEEN   4
// Reset values
`define SHACS_CTRL_RST      32'h0000_0001
// Serial word
`define SHACS_WR_BITS       10
`define SHACS_RD_BITS       14
`define SHACS_TEST_BITS     24
`define SHACS_MODE_SHA      2'h0
`define SHACS_MODE_TEST     2'h1
`define SHACS_MODE_ACQRB    2'h2
`define SHACS_MODE_RB       2'h3
// Timing, ns and cycles at 40 ns
`define SHACS_CLK_NS        40
`define SHACS_ACQ_NS        16000
`define SHACS_CAL_NS        45000
`define SHACS_RST_MIN_NS    50
`define SHACS_RST_MAX_NS    150
`define SHACS_ACQ_CYC  ((`SHACS_ACQ_NS) / (`SHACS_CLK_NS))
`define SHACS_CAL_CYC  ((`SHACS_CAL_NS) / (`SHACS_CLK_NS))
`define SHACS_RST_MIN_CYC \
  (((`SHACS_RST_MIN_NS) + (`SHACS_CLK_NS) - 1) / (`SHACS_CLK_NS))
`define SHACS_RST_MAX_CYC  ((`SHACS_RST_MAX_NS) / (`SHACS_CLK_NS))
`endif

// ==== rtl/shacs_top.v ====
`timescale 1ns/100ps
`include "shacs_defs.vh"
module shacs_top #(
  parameter ACQ_CYC = `SHACS_ACQ_CYC,
  parameter CAL_CYC = `SHACS_CAL_CYC,
  parameter NCH     = 32
) (
  input  wire        CLK_I,          // 25 MHz clock
  input  wire        RST_I,          // Async reset, high
  input  wire        SCLK_I,         // Serial clock pin
  input  wire        SYNC_N_I,       // Frame select / chip select, low
  input  wire        SDIN_I,         // Serial data in
  output wire        SDOUT_O,        // Serial data out
  output wire        SDOUT_OE_N_O,   // Low while driving serial out
  input  wire        WR_N_I,         // Parallel write strobe, low
  input  wire [4:0]  CHANNEL_ADDRESS_I, // Parallel channel address
  input  wire        OFFSET_SEL_I,   // Parallel offset select
  input  wire        CAL_I,          // Parallel all-channel acquire
  input  wire        TRACK_N_RESET_I, // Track pin, short low is reset
  output wire        BUSY_N_O,       // Acquisition busy, low
  output wire [32:0] INPUT_ROUTE_O,  // Per channel: output follows input
  input  wire [13:0] ADC_CODE_I,     // Converter result for acquisition
  input  wire [31:0] S_AXI_AWADDR,   // AXI write address
  input  wire        S_AXI_AWVALID,  // AXI write address valid
  output wire        S_AXI_AWREADY,  // AXI write address ready
  input  wire [31:0] S_AXI_WDATA,    // AXI write data
  input  wire [3:0]  S_AXI_WSTRB,    // AXI write strobes
  input  wire        S_AXI_WVALID,   // AXI write data valid
  output wire        S_AXI_WREADY,   // AXI write data ready
  output wire [1:0]  S_AXI_BRESP,    // AXI write response
  output wire        S_AXI_BVALID,   // AXI write response valid
  input  wire        S_AXI_BREADY,   // AXI write response ready
  input  wire [31:0] S_AXI_ARADDR,   // AXI read address
  input  wire        S_AXI_ARVALID,  // AXI read address valid
  output wire        S_AXI_ARREADY,  // AXI read address ready
  output wire [31:0] S_AXI_RDATA,    // AXI read data
  output wire [1:0]  S_AXI_RRESP,    // AXI read response
  output wire        S_AXI_RVALID,   // AXI read valid
  input  wire        S_AXI_RREADY    // AXI read ready
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_ACQ  = 2'h2;
  localparam CH_OFS  = 6'h20;
  // Counts held at 32 bits, then cut on purpose to the counter widths
  localparam [31:0] ACQ_W    = ACQ_CYC;
  localparam [31:0] CAL_W    = CAL_CYC;
  localparam [31:0] RMIN_W   = `SHACS_RST_MIN_CYC;
  localparam [31:0] RMAX_W   = `SHACS_RST_MAX_CYC;
  localparam [31:0] RD_W     = `SHACS_RD_BITS;
  localparam [31:0] WR_W     = `SHACS_WR_BITS;
  localparam [31:0] TEST_W   = `SHACS_TEST_BITS;
  localparam [3:0]  RMIN     = RMIN_W[3:0];
  localparam [3:0]  RMAX     = RMAX_W[3:0];
  localparam [4:0]  RD_LEN   = RD_W[4:0];
  localparam [4:0]  WR_LEN   = WR_W[4:0];
  localparam [4:0]  TEST_LEN = TEST_W[4:0];
  localparam [10:0] ACQ_LEN  = ACQ_W[10:0];
  localparam [10:0] CAL_LEN  = CAL_W[10:0];

  // Three-stage synchronisers for pins
  reg [2:0] sclk_s_reg, sync_s_reg, din_s_reg, wr_s_reg, trk_s_reg;
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sclk_s_reg <= 3'h0;
      sync_s_reg <= 3'h7;
      din_s_reg  <= 3'h0;
      wr_s_reg   <= 3'h7;
      trk_s_reg  <= 3'h7;
    end else begin
      sclk_s_reg <= {sclk_s_reg[1:0], SCLK_I};
      sync_s_reg <= {sync_s_reg[1:0], SYNC_N_I};
      din_s_reg  <= {din_s_reg[1:0], SDIN_I};
      wr_s_reg   <= {wr_s_reg[1:0], WR_N_I};
      trk_s_reg  <= {trk_s_reg[1:0], TRACK_N_RESET_I};
    end
  end

  // Filtered levels: change only when stages two and three agree
  reg sclk_f_reg, sync_f_reg, wr_f_reg, trk_f_reg;
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sclk_f_reg <= 1'b0;
      sync_f_reg <= 1'b1;
      wr_f_reg   <= 1'b1;
      trk_f_reg  <= 1'b1;
    end else begin
      if (sclk_s_reg[1] == sclk_s_reg[2])
        sclk_f_reg <= sclk_s_reg[2];
      if (sync_s_reg[1] == sync_s_reg[2])
        sync_f_reg <= sync_s_reg[2];
      if (wr_s_reg[1] == wr_s_reg[2])
        wr_f_reg <= wr_s_reg[2];
      if (trk_s_reg[1] == trk_s_reg[2])
        trk_f_reg <= trk_s_reg[2];
    end
  end
  wire sclk_fall = sclk_f_reg & ~sclk_s_reg[2] & ~sclk_s_reg[1];
  wire sclk_rise = ~sclk_f_reg & sclk_s_reg[2] & sclk_s_reg[1];
  wire sync_fall = sync_f_reg & ~sync_s_reg[2] & ~sync_s_reg[1];
  wire wr_rise   = ~wr_f_reg & wr_s_reg[2] & wr_s_reg[1];
  wire trk_lvl_n = ~trk_f_reg;

  // Software control register
  reg  [31:0] ctrl_reg;
  wire        ser_en = ctrl_reg[`SHACS_CTRL_SERIAL];

  // Track pin pulse width: short low is reset, long low is track
  reg  [3:0] trk_cnt_reg;
  reg        soft_rst_reg;
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      trk_cnt_reg  <= 4'h0;
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= 1'b0;
      if (trk_lvl_n) begin
        if (trk_cnt_reg != 4'hf)
          trk_cnt_reg <= trk_cnt_reg + 4'h1;
      end else begin
        trk_cnt_reg <= 4'h0;
        if (trk_cnt_reg >= RMIN &&
            trk_cnt_reg <= RMAX)
          soft_rst_reg <= 1'b1;
      end
    end
  end
  // Track counts as low only once longer than the reset window
  wire trk_low  = trk_lvl_n && trk_cnt_reg > RMAX;
  reg  trk_low_q_reg;
  wire trk_rise = trk_low_q_reg & ~trk_lvl_n;

  // Serial frame engine
  reg        frm_act_reg, rb_act_reg, test_reg, rb_pend_reg;
  reg [4:0]  bit_cnt_reg;
  reg [9:0]  sh_in_reg;
  reg [13:0] sh_out_reg;
  reg        dout_reg, doe_n_reg;
  reg [5:0]  rb_ch_reg;
  reg        cmd_go_reg, cmd_acq_reg, cmd_cal_reg;
  reg [5:0]  cmd_ch_reg;
  reg [13:0] dac_mem [0:NCH];
  wire [4:0] frm_len = test_reg ? TEST_LEN :
                       rb_act_reg ? RD_LEN :
                       WR_LEN;
  wire [9:0] word = {sh_in_reg[8:0], din_s_reg[2]};

  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      frm_act_reg <= 1'b0;
      rb_act_reg  <= 1'b0;
      rb_pend_reg <= 1'b0;
      test_reg    <= 1'b0;
      bit_cnt_reg <= 5'h0;
      sh_in_reg   <= 10'h000;
      sh_out_reg  <= 14'h0000;
      dout_reg    <= 1'b0;
      doe_n_reg   <= 1'b1;
      rb_ch_reg   <= 6'h00;
      cmd_go_reg  <= 1'b0;
      cmd_acq_reg <= 1'b0;
      cmd_cal_reg <= 1'b0;
      cmd_ch_reg  <= 6'h00;
    end else if (soft_rst_reg) begin
      frm_act_reg <= 1'b0;
      rb_act_reg  <= 1'b0;
      rb_pend_reg <= 1'b0;
      test_reg    <= 1'b0;
      doe_n_reg   <= 1'b1;
      cmd_go_reg  <= 1'b0;
    end else begin
      cmd_go_reg <= 1'b0;
      if (ser_en && sync_fall && !frm_act_reg) begin
        frm_act_reg <= 1'b1;
        bit_cnt_reg <= 5'h0;
        rb_act_reg  <= rb_pend_reg && !test_reg;
        rb_pend_reg <= 1'b0;
        sh_out_reg  <= dac_mem[rb_ch_reg];
      end else if (ser_en && frm_act_reg) begin
        if (sclk_rise && rb_act_reg && bit_cnt_reg < RD_LEN) begin
          dout_reg   <= sh_out_reg[13];
          sh_out_reg <= {sh_out_reg[12:0], 1'b0};
          doe_n_reg  <= 1'b0;
        end
        if (sclk_fall) begin
          bit_cnt_reg <= bit_cnt_reg + 5'h1;
          if (!rb_act_reg)
            sh_in_reg <= word;
          if (bit_cnt_reg + 5'h1 == frm_len) begin
            frm_act_reg <= 1'b0;
            doe_n_reg   <= 1'b1;
            rb_act_reg  <= 1'b0;
            if (test_reg)
              test_reg <= 1'b0;
            else if (!rb_act_reg) begin
              case (word[9:8])
                `SHACS_MODE_TEST: test_reg <= 1'b1;
                default: begin
                  rb_pend_reg <= word[9];
                  rb_ch_reg   <= word[6] ? CH_OFS : {1'b0, word[4:0]};
                  cmd_go_reg  <= 1'b1;
                  cmd_acq_reg <= !word[8];
                  cmd_cal_reg <= word[7];
                  cmd_ch_reg  <= word[6] ? CH_OFS : {1'b0, word[4:0]};
                end
              endcase
            end
          end
        end
      end else if (!ser_en && wr_rise && !sync_f_reg) begin
        cmd_go_reg  <= 1'b1;
        cmd_acq_reg <= 1'b1;
        cmd_cal_reg <= CAL_I;
        cmd_ch_reg  <= OFFSET_SEL_I ? CH_OFS : {1'b0, CHANNEL_ADDRESS_I};
      end
    end
  end

  // Acquisition sequencer
  reg [1:0]  acq_st_reg;
  reg [10:0] acq_cnt_reg;
  reg [5:0]  acq_ch_reg;
  reg        acq_cal_reg;
  reg [32:0] route_reg;
  reg [13:0] result_reg;
  integer i;
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      acq_st_reg    <= ST_IDLE;
      acq_cnt_reg   <= 11'h000;
      acq_ch_reg    <= 6'h00;
      acq_cal_reg   <= 1'b0;
      route_reg     <= 33'h0;
      result_reg    <= 14'h0000;
      trk_low_q_reg <= 1'b0;
      for (i = 0; i <= NCH; i = i + 1)
        dac_mem[i] <= 14'h0000;
    end else if (soft_rst_reg) begin
      acq_st_reg <= ST_IDLE;
      route_reg  <= 33'h0;
      for (i = 0; i <= NCH; i = i + 1)
        dac_mem[i] <= 14'h0000;
    end else begin
      trk_low_q_reg <= trk_low;
      case (acq_st_reg)
        ST_IDLE: begin
          if (cmd_go_reg && cmd_acq_reg) begin
            acq_ch_reg  <= cmd_ch_reg;
            acq_cal_reg <= cmd_cal_reg;
            acq_cnt_reg <= cmd_cal_reg ? CAL_LEN : ACQ_LEN;
            if (cmd_cal_reg)
              route_reg <= {1'b0, {32{1'b1}}};
            else
              route_reg[cmd_ch_reg] <= 1'b1;
            acq_st_reg <= trk_low ? ST_WAIT : ST_ACQ;
          end
        end
        ST_WAIT: begin
          if (trk_rise)
            acq_st_reg <= ST_ACQ;
        end
        ST_ACQ: begin
          if (acq_cnt_reg <= 11'h001) begin
            acq_st_reg <= ST_IDLE;
            route_reg  <= 33'h0;
            result_reg <= ADC_CODE_I;
            if (acq_cal_reg) begin
              for (i = 0; i < NCH; i = i + 1)
                dac_mem[i] <= ADC_CODE_I;
            end else
              dac_mem[acq_ch_reg] <= ADC_CODE_I;
          end else
            acq_cnt_reg <= acq_cnt_reg - 11'h001;
        end
        default: acq_st_reg <= ST_IDLE;
      endcase
    end
  end

  assign BUSY_N_O     = (acq_st_reg != ST_ACQ);
  assign INPUT_ROUTE_O = route_reg;
  assign SDOUT_O      = dout_reg;
  assign SDOUT_OE_N_O = doe_n_reg;

  // AXI4-Lite slave, one outstanding write and read
  reg        aw_ok_reg, w_ok_reg, bv_reg, rv_reg;
  // Whole address kept so aliases above the map answer with an error
  reg [31:0] awa_reg;
  reg [31:0] wd_reg, rd_reg;
  reg [1:0]  rresp_reg, bresp_reg;
  wire       wr_go = aw_ok_reg && w_ok_reg && !bv_reg;
  assign S_AXI_AWREADY = !aw_ok_reg && !bv_reg;
  assign S_AXI_WREADY  = !w_ok_reg && !bv_reg;
  assign S_AXI_BVALID  = bv_reg;
  assign S_AXI_BRESP   = bresp_reg;
  assign S_AXI_ARREADY = !rv_reg;
  assign S_AXI_RVALID  = rv_reg;
  assign S_AXI_RDATA   = rd_reg;
  assign S_AXI_RRESP   = rresp_reg;
  wire [31:0] status = {27'h0, 1'b0, rb_pend_reg, |route_reg,
                        test_reg, BUSY_N_O};
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      aw_ok_reg <= 1'b0;
      w_ok_reg  <= 1'b0;
      bv_reg    <= 1'b0;
      rv_reg    <= 1'b0;
      awa_reg   <= 32'h0;
      wd_reg    <= 32'h0;
      rd_reg    <= 32'h0;
      rresp_reg <= 2'h0;
      bresp_reg <= 2'h0;
      ctrl_reg  <= `SHACS_CTRL_RST;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_ok_reg <= 1'b1;
        awa_reg   <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_ok_reg <= 1'b1;
        if (S_AXI_WSTRB[0])
          wd_reg <= S_AXI_WDATA;
      end
      if (wr_go) begin
        aw_ok_reg <= 1'b0;
        w_ok_reg  <= 1'b0;
        bv_reg    <= 1'b1;
        bresp_reg <= (awa_reg == {28'h0, `SHACS_ADDR_CTRL}) ? 2'h0 : 2'h2;
        if (awa_reg == {28'h0, `SHACS_ADDR_CTRL})
          ctrl_reg <= {31'h0, wd_reg[0]};
      end else if (bv_reg && S_AXI_BREADY)
        bv_reg <= 1'b0;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        rv_reg    <= 1'b1;
        rresp_reg <= 2'h0;
        case (S_AXI_ARADDR)
          {28'h0, `SHACS_ADDR_CTRL}:   rd_reg <= ctrl_reg;
          {28'h0, `SHACS_ADDR_STATUS}: rd_reg <= status;
          {28'h0, `SHACS_ADDR_CHSEL}:  rd_reg <= {26'h0, rb_ch_reg};
          {28'h0, `SHACS_ADDR_RESULT}: rd_reg <= {18'h0, result_reg};
          default: begin
            rd_reg    <= 32'h0;
            rresp_reg <= 2'h2;
          end
        endcase
      end else if (rv_reg && S_AXI_RREADY)
        rv_reg <= 1'b0;
    end
  end
endmodule // shacs_top

// ==== sim/shacs_sva.sv ====
`timescale 1ns/100ps
module shacs_sva #(
  parameter ACQ_CYC = 400,
  parameter CAL_CYC = 1125
) (
  input wire        CLK_I,           // Clock
  input wire        RST_I,           // Reset
  input wire        SYNC_N_I,        // Frame select
  input wire        TRACK_N_RESET_I, // Track pin
  input wire        SDOUT_OE_N_O,    // Out enable
  input wire        BUSY_N_O,        // Busy
  input wire [32:0] INPUT_ROUTE_O,   // Routes
  input wire [31:0] S_AXI_ARADDR,    // AR address
  input wire        S_AXI_ARVALID,   // AR valid
  input wire        S_AXI_ARREADY,   // AR ready
  input wire [31:0] S_AXI_RDATA,     // R data
  input wire [1:0]  S_AXI_RRESP,     // R resp
  input wire        S_AXI_RVALID,    // R valid
  input wire        S_AXI_RREADY,    // R ready
  input wire        S_AXI_BVALID,    // B valid
  input wire        S_AXI_BREADY     // B ready
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  reg [11:0] low_reg;
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) low_reg <= 12'h000;
    else low_reg <= BUSY_N_O ? 12'h000 : low_reg + 12'h001;
  end
  // One cycle of slack for the pin synchroniser
  chk_busy_len: assert property ($rose(BUSY_N_O) |->
    (low_reg >= ACQ_CYC - 1 && low_reg <= ACQ_CYC + 1) ||
    (low_reg >= CAL_CYC - 1 && low_reg <= CAL_CYC + 1))
    else $error("busy low time wrong");
  chk_route_done: assert property ($rose(BUSY_N_O) |->
    ##[0:2] INPUT_ROUTE_O == 33'h0) else $error("route kept");
  chk_track_wait: assert property (!TRACK_N_RESET_I [*8] |->
    BUSY_N_O) else $error("acquired with track low");
  chk_oe_frame: assert property ($fell(SDOUT_OE_N_O) |->
    !SYNC_N_I) else $error("output enabled outside frame");
  chk_oe_idle: assert property (SYNC_N_I [*8] |->
    SDOUT_OE_N_O) else $error("output driven while idle");
  chk_r_latency: assert property (S_AXI_ARVALID && S_AXI_ARREADY
    |=> S_AXI_RVALID) else $error("read answer late");
  chk_r_drop: assert property (S_AXI_RVALID && S_AXI_RREADY
    |=> !S_AXI_RVALID) else $error("read valid stuck");
  chk_b_drop: assert property (S_AXI_BVALID && S_AXI_BREADY
    |=> !S_AXI_BVALID) else $error("write resp stuck");
  chk_unmapped_rd: assert property (S_AXI_ARVALID && S_AXI_ARREADY
    && S_AXI_ARADDR[31:4] != 28'h0 |=> S_AXI_RRESP == 2'h2
    && S_AXI_RDATA == 32'h0) else $error("unmapped read answered");
endmodule // shacs_sva
bind shacs_top shacs_sva #(.ACQ_CYC(ACQ_CYC), .CAL_CYC(CAL_CYC)) i_shacs_sva (
  .CLK_I(CLK_I), .RST_I(RST_I), .SYNC_N_I(SYNC_N_I),
  .TRACK_N_RESET_I(TRACK_N_RESET_I), .SDOUT_OE_N_O(SDOUT_OE_N_O),
  .BUSY_N_O(BUSY_N_O), .INPUT_ROUTE_O(INPUT_ROUTE_O),
  .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY));

// ==== sim/shacs_host.sv ====
`timescale 1ns/100ps
module shacs_host (
  output logic      sclk_o,      // Link clock, idle low
  output logic      sync_n_o,    // Frame select
  output logic      sdin_o,      // Serial data
  input  wire logic sdout_i,     // Readback data
  input  wire logic sdout_oe_n_i // Readback enable
);
  logic [23:0] rd;
  logic [23:0] oe;
  initial begin
    sclk_o = 1'b0;
    sync_n_o = 1'b1;
    sdin_o = 1'b0;
  end
  // Sample half a phase after the fall: the pins cross a synchroniser
  task automatic frame(input int n, input logic [23:0] w, input bit rb,
                       input int hp);
    #7;
    sync_n_o = 1'b0;
    #hp;
    for (int i = n - 1; i >= 0; i--) begin
      sdin_o = rb ? 1'($urandom) : w[i];
      sclk_o = 1'b1;
      #hp;
      sclk_o = 1'b0;
      #(hp / 2);
      rd = {rd[22:0], sdout_i};
      oe = {oe[22:0], sdout_oe_n_i};
      #(hp - hp / 2);
    end
    #hp;
    sync_n_o = 1'b1;
    sdin_o = ~sdin_o;
    #(4 * hp);
  endtask
  task automatic cs(input logic v);
    #7;
    sync_n_o = v;
  endtask
endmodule // shacs_host

// ==== sim/shacs_tb_top.sv ====
`timescale 1ns/100ps
module shacs_tb_top;
  logic CLK_I = 0, RST_I = 1, WR_N_I = 1, OFFSET_SEL_I = 0, CAL_I = 0;
  logic TRACK_N_RESET_I = 1, S_AXI_AWVALID = 0, S_AXI_WVALID = 0;
  logic S_AXI_BREADY = 0, S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
  logic [4:0] CHANNEL_ADDRESS_I = 0;
  logic [13:0] ADC_CODE_I = 0;
  logic [31:0] S_AXI_AWADDR = 0, S_AXI_WDATA = 0, S_AXI_ARADDR = 0;
  logic [3:0] S_AXI_WSTRB = 4'hf;
  wire SCLK_I, SYNC_N_I, SDIN_I, SDOUT_O, SDOUT_OE_N_O, BUSY_N_O;
  wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  wire S_AXI_RVALID;
  wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
  wire [31:0] S_AXI_RDATA;
  wire [32:0] INPUT_ROUTE_O;
  logic [13:0] mem [0:32];
  int fail_count = 0;
  int num_checks = 0;
  // Short counts keep the run brief
  shacs_top #(.ACQ_CYC(20), .CAL_CYC(30)) i_shacs_top (.*);
  shacs_host i_shacs_host (.sclk_o(SCLK_I), .sync_n_o(SYNC_N_I),
    .sdin_o(SDIN_I), .sdout_i(SDOUT_O), .sdout_oe_n_i(SDOUT_OE_N_O));
  always #20 CLK_I = ~CLK_I;
  function automatic logic [9:0] word(input logic [1:0] m,
                                      input logic c, o, input logic [4:0] a);
    return {m, c, o, 1'b0, a};
  endfunction
  function automatic logic [32:0] exp_route(input logic c, o,
                                             input logic [4:0] a);
    if (c) return {1'b0, {32{1'b1}}};
    if (o) return {1'b1, 32'h0};
    return 33'h1 << a;
  endfunction
  task automatic chk(input logic [39:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic v);
    int n = 0;
    while (BUSY_N_O !== v && n < 3000) begin
      @(posedge CLK_I);
      n++;
    end
    chk(n < 3000, 1);
  endtask
  task automatic store(input logic c, o, input logic [4:0] a,
                       input logic [13:0] v);
    for (int i = 0; i < 32; i++) if (c) mem[i] = v;
    if (!c) mem[o ? 32 : a] = v;
  endtask
  task automatic axw(input logic [31:0] a, dt, output logic [1:0] r);
    @(posedge CLK_I);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= dt;
    S_AXI_AWVALID <= 1;
    S_AXI_WVALID <= 1;
    S_AXI_BREADY <= 1;
    do begin
      @(posedge CLK_I);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 0;
    end while (S_AXI_BVALID !== 1);
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 0;
  endtask
  task automatic axr(input logic [31:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge CLK_I);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1;
    S_AXI_RREADY <= 1;
    do begin
      @(posedge CLK_I);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 0;
    end while (S_AXI_RVALID !== 1);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 0;
  endtask
  task automatic rb(input logic [1:0] m, input logic o, input logic [4:0] a);
    if (m != 2) begin
      i_shacs_host.frame(10, word(3, 0, o, a), 0, 160);
      repeat (8) @(posedge CLK_I);
      chk(BUSY_N_O, 1);
    end
    i_shacs_host.frame(14, 0, 1, 160);
    chk(i_shacs_host.rd[13:0], mem[o ? 32 : a]);
    chk(i_shacs_host.oe[13:0], 0);
    chk(SDOUT_OE_N_O, 1);
  endtask
  task automatic acq(input logic [1:0] m, input logic c, o,
                     input logic [4:0] a);
    logic [13:0] v = 14'($urandom);
    @(posedge CLK_I);
    ADC_CODE_I <= v;
    i_shacs_host.frame(10, word(m, c, o, a), 0, 160);
    wb(0);
    chk(INPUT_ROUTE_O, exp_route(c, o, a));
    wb(1);
    chk(INPUT_ROUTE_O, 0);
    store(c, o, a, v);
    rb(m, o, c ? 5'h0 : a);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #2_000_000;
    fail_count++;
    print_verdict;
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [4:0] a;
    d = $urandom(28);
    for (int i = 0; i < 33; i++) mem[i] = 0;
    repeat (3) @(posedge CLK_I);
    RST_I <= 0;
    @(posedge CLK_I);
    chk({BUSY_N_O, SDOUT_OE_N_O, INPUT_ROUTE_O}, {2'b11, 33'h0});
    axr(0, d, r);
    chk({d, r}, 34'h4);
    axr(32'h10, d, r);
    chk({d, r}, 34'h2);
    axw(32'h8, 5, r);
    chk(r, 2);
    rb(3, 0, 5'($urandom));
    acq(0, 0, 0, 0);
    acq(2, 0, 0, 31);
    acq(0, 1, 0, 5'($urandom));
    for (int k = 0; k < 5; k++) acq(k[0] ? 2 : 0, 0, k == 3, 5'($urandom));
    i_shacs_host.frame(10, word(1, 0, 0, 3), 0, 160);
    repeat (8) @(posedge CLK_I);
    chk(BUSY_N_O, 1);
    i_shacs_host.frame(24, 0, 0, 400);
    acq(2, 0, 0, 3);
    a = 5'($urandom);
    TRACK_N_RESET_I <= 0;
    i_shacs_host.frame(10, word(0, 0, 0, a), 0, 160);
    repeat (10) @(posedge CLK_I);
    chk({BUSY_N_O, INPUT_ROUTE_O}, {1'b1, exp_route(0, 0, a)});
    store(0, 0, a, ADC_CODE_I);
    TRACK_N_RESET_I <= 1;
    wb(0);
    wb(1);
    rb(3, 0, a);
    TRACK_N_RESET_I <= 0;
    @(posedge CLK_I);
    TRACK_N_RESET_I <= 1;
    rb(3, 0, a);
    TRACK_N_RESET_I <= 0;
    repeat (2) @(posedge CLK_I);
    TRACK_N_RESET_I <= 1;
    repeat (10) @(posedge CLK_I);
    for (int i = 0; i < 33; i++) mem[i] = 0;
    rb(3, 0, a);
    axw(0, 0, r);
    for (int p = 0; p < 3; p++) begin
      @(posedge CLK_I);
      ADC_CODE_I <= 14'($urandom);
      CHANNEL_ADDRESS_I <= a;
      CAL_I <= p == 2;
      OFFSET_SEL_I <= p == 1;
      i_shacs_host.cs(0);
      repeat (2) @(posedge CLK_I);
      WR_N_I <= 0;
      repeat (3) @(posedge CLK_I);
      WR_N_I <= 1;
      repeat (6) @(posedge CLK_I);
      CHANNEL_ADDRESS_I <= ~a;
      wb(0);
      chk(INPUT_ROUTE_O, exp_route(p == 2, p == 1, a));
      wb(1);
      store(p == 2, p == 1, a, ADC_CODE_I);
      i_shacs_host.cs(1);
    end
    i_shacs_host.frame(10, word(0, 0, 0, a), 0, 160);
    repeat (10) @(posedge CLK_I);
    chk(BUSY_N_O, 1);
    axw(0, 1, r);
    rb(3, 1, 0);
    print_verdict;
  end
endmodule // shacs_tb_top
